// ===== logic/sdc_doze_div.sv
// Doze divider that paces CPU instruction cycles against peripheral cycles.
`timescale 1ns/1ps
`default_nettype none
module sdc_doze_div (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_periph_en,  // Peripheral instruction cycle pulse.
  input  wire logic       i_reduced,    // Reduced speed in force.
  input  wire logic [2:0] i_ratio,      // Ratio code.
  output logic            o_cpu_en      // CPU instruction cycle enable.
);
  import sdc_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
  } sdc_div_st_t;

  sdc_div_st_t s_q, s_d;  // Divider state.

  // Terminal count for a code: 000 gives 1:2, each step doubles, 111 gives 1:256.
  function automatic logic [7:0] ratio_last(input logic [2:0] code);
    logic [8:0] full;
    full = 9'h002 << code;  // RULE11
    ratio_last = 8'(full - 9'h001);
  endfunction : ratio_last

  // The CPU takes one cycle in each group of peripheral cycles.
  always_comb begin
    s_d = s_q;
    o_cpu_en = 1'b0;
    if (!i_reduced) begin
      s_d.cnt  = 8'h00;
      o_cpu_en = i_periph_en;  // RULE8
    end else if (i_periph_en) begin
      o_cpu_en = (s_q.cnt == 8'h00);  // RULE8
      s_d.cnt  = (s_q.cnt >= ratio_last(i_ratio)) ? 8'h00 : s_q.cnt + 8'h01;
    end
  end

  // Register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '{cnt: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

endmodule : sdc_doze_div
`default_nettype wire

// ===== logic/sdc_ost.sv
// Oscillator start-up timer that gates the fail-safe clock monitor.
`timescale 1ns/1ps
`default_nettype none
module sdc_ost #(
  parameter int CYCLES = sdc_pkg::SDC_OST_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_start,     // Restart the timer.
  input  wire logic i_bypass,    // External clock: no timer needed.
  output logic      o_running,   // Timer counting.
  output logic      o_expired    // Monitor may check.
);
  import sdc_pkg::*;

  localparam int W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         run;
    logic         done;
  } sdc_ost_st_t;

  sdc_ost_st_t s_q, s_d;  // Timer state.

  // Next state: a start either bypasses or reloads the counter.
  always_comb begin
    s_d = s_q;
    if (i_start) begin
      if (i_bypass) begin
        s_d.run  = 1'b0;  // RULE6
        s_d.done = 1'b1;  // RULE6
      end else begin
        s_d.run  = 1'b1;  // RULE5
        s_d.done = 1'b0;  // RULE4
        s_d.cnt  = W'(CYCLES - 1);
      end
    end else if (s_q.run) begin
      if (s_q.cnt == '0) begin
        s_d.run  = 1'b0;
        s_d.done = 1'b1;  // RULE4
      end else begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end

  // Registers; after reset the timer is counting, as every reset runs it.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '{cnt: W'(CYCLES - 1), run: 1'b1, done: 1'b0};  // RULE5
    end else begin
      s_q <= s_d;
    end
  end

  assign o_running = s_q.run;
  assign o_expired = s_q.done;

endmodule : sdc_ost
`default_nettype wire

// ===== logic/sdc_pkg.sv
// Package of constants and types for the sleep and doze clock control block.
package sdc_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] SDC_OFF_DOZE_IDLE = 8'h00;  // Doze and idle control.
  localparam logic [7:0] SDC_OFF_OSC_SEL   = 8'h04;  // Oscillator selection control.
  localparam logic [7:0] SDC_OFF_STATUS    = 8'h08;  // Sticky event status, cleared on read.
  localparam logic [7:0] SDC_OFF_MASK      = 8'h0c;  // Interrupt mask.
  localparam logic [7:0] SDC_OFF_STATE     = 8'h10;  // Live clock state, read only.

  // Field positions in the doze and idle control register.
  localparam int SDC_BIT_IDLE_SEL  = 7;  // Idle select.
  localparam int SDC_BIT_REDUCED   = 6;  // Reduced speed active.
  localparam int SDC_BIT_WAKE_FULL = 5;  // Wake full on interrupt.
  localparam int SDC_BIT_RED_RET   = 4;  // Reduced on return.
  localparam int SDC_RATIO_LSB     = 0;  // Ratio field, three bits.

  // Field positions in the oscillator selection register.
  localparam int SDC_BIT_HOLD      = 3;  // Switch hold.
  localparam int SDC_BIT_EXT_CLK   = 4;  // External clock mode selected.
  localparam int SDC_SEL_LSB       = 0;  // Source code, three bits.

  // Status and mask bit positions.
  localparam int SDC_EV_SWITCH_DONE = 0;  // Clock switch done flag.
  localparam int SDC_EV_OSC_FAIL    = 1;  // Fail-safe monitor saw a failure.
  localparam int SDC_EV_WAKE        = 2;  // Woke from sleep.

  // Reset values.
  localparam logic [7:0] SDC_RST_DOZE_IDLE = 8'h00;
  localparam logic [7:0] SDC_RST_OSC_SEL   = 8'h00;
  localparam logic [2:0] SDC_RST_MASK      = 3'h0;

  // Start-up timer length in oscillator periods and the switch settle time.
  localparam int SDC_OST_CYCLES    = 1024;
  localparam int SDC_SWITCH_CYCLES = 16;

  // Power state of the device.
  typedef enum logic [1:0] {
    SDC_RUN,
    SDC_IDLE,
    SDC_SLEEP,
    SDC_OST
  } sdc_pwr_t;

endpackage : sdc_pkg

// ===== logic/sdc_top.sv
// Top of the sleep, idle and doze clock control block with its APB registers.
// Notes on behaviour
// RULE1 - Sleep during pending switch abandons the switch.
// RULE2 - Wake, hold clear: new clock, flag set.
// RULE3 - Wake, hold set: old clock, request again.
// RULE4 - Fail-safe monitor checks only after timer expiry.
// RULE5 - Start-up timer runs after wake and reset.
// RULE6 - External clock skips timer; monitor active immediately.
// RULE7 - Idle select chooses idle or full sleep.
// RULE8 - Reduced speed uses ratio, else full speed.
// RULE9 - Wake-full bit clears reduced speed on interrupt.
// RULE10 - Reduced-on-return bit sets reduced speed on return.
// RULE11 - Ratio code gives one to two through 256.
// RULE12 - Debug forces full speed, stored bit untouched.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sdc_top #(
  parameter int OST_CYCLES    = sdc_pkg::SDC_OST_CYCLES,
  parameter int SWITCH_CYCLES = sdc_pkg::SDC_SWITCH_CYCLES
) (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  // APB slave.
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic             O_PREADY,
  output logic [31:0]      O_PRDATA,
  output logic             O_PSLVERR,
  // CPU core events.
  input  wire logic        I_SLEEP_INSN,      // One-cycle pulse: SLEEP executed.
  input  wire logic        I_WAKE,            // Level: wake source pending.
  input  wire logic        I_ISR_ENTRY,       // One-cycle pulse: interrupt taken.
  input  wire logic        I_RETURN_INT,      // One-cycle pulse: return from interrupt.
  input  wire logic        I_DEBUG,           // Level: in-circuit debug active.
  input  wire logic        I_PERIPH_EN,       // Peripheral instruction cycle pulse.
  input  wire logic        I_OSC_FAIL,        // Level: clock monitor sees no clock.
  // Clock control outputs.
  output logic             O_CPU_EN,          // CPU instruction cycle enable.
  output logic             O_CPU_CLK_RUN,     // CPU clock allowed.
  output logic             O_PERIPH_CLK_RUN,  // Peripheral clocks allowed.
  output logic [2:0]       O_ACTIVE_SEL,      // Oscillator source in use.
  output logic             O_SWITCH_REQ,      // Request to bring up the new source.
  output logic             O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE,     // Fail-safe monitor checking.
  output logic             O_IRQ              // Level interrupt.
);
  import sdc_pkg::*;

  // Width of the switch settle counter.
  // It holds SWITCH_CYCLES - 1 at most, so the codes from SWITCH_CYCLES upward are never used.
  localparam int SW_W = $clog2(SWITCH_CYCLES + 1);

  typedef struct packed {
    logic [7:0]      dz;          // Doze and idle control.
    logic [7:0]      osc;         // Oscillator selection control.
    logic [2:0]      active;      // Source in use.
    logic            pend;        // Switch pending.
    logic [SW_W-1:0] sw_cnt;      // Switch settle counter.
    logic            wake_retry;  // Switch dropped on the way into sleep, taken up again at wake.
    logic [2:0]      status;      // Sticky events.
    logic [2:0]      mask;        // Interrupt mask.
    sdc_pwr_t        pwr;         // Power state.
    logic            ready;       // APB answer.
    logic [31:0]     rdata;       // APB read data.
    logic            slverr;      // APB error.
    logic            cpu_en;      // Registered CPU enable.
    logic            irq;         // Registered interrupt.
    logic            fail_safe_clock_monitor;        // Registered monitor enable.
    logic            cpu_run;     // Registered CPU clock allow.
    logic            periph_run;  // Registered peripheral clock allow.
  } sdc_top_st_t;

  sdc_top_st_t s_q, s_d;  // Whole block state.

  // Glue between the state register and the two helper modules.
  // The timer start is combinational so the reload lands on the wake edge.
  logic ost_start;    // Kick the start-up timer.
  logic ost_expired;  // Timer done or bypassed.
  logic doze_en;      // Divider output.
  logic reduced_eff;  // Reduced speed after debug override.

  // True when an address names a mapped register.
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == SDC_OFF_DOZE_IDLE) || (a == SDC_OFF_OSC_SEL) ||
               (a == SDC_OFF_STATUS) || (a == SDC_OFF_MASK) || (a == SDC_OFF_STATE);
  endfunction : addr_hit

  // Debug override is applied to the divider only, so the stored bit survives.
  assign reduced_eff = s_q.dz[SDC_BIT_REDUCED] && !I_DEBUG;  // RULE12

  // Start-up timer; the external clock selection bypasses it.
  sdc_ost #(
    .CYCLES    (OST_CYCLES)
  ) u_ost (
    .i_clk     (I_CORE_CLK),
    .i_rst_n   (I_RST_N),
    .i_start   (ost_start),
    .i_bypass  (s_q.osc[SDC_BIT_EXT_CLK]),
    .o_running (),
    .o_expired (ost_expired)
  );

  // Doze divider.
  sdc_doze_div u_div (
    .i_clk       (I_CORE_CLK),
    .i_rst_n     (I_RST_N),
    .i_periph_en (I_PERIPH_EN),
    .i_reduced   (reduced_eff),
    .i_ratio     (s_q.dz[SDC_RATIO_LSB +: 3]),
    .o_cpu_en    (doze_en)
  );

  // Main next-state logic: bus, power state, clock switch and interrupt.
  always_comb begin
    logic       setup;
    logic       access;
    logic [2:0] ev;
    setup  = 1'b0;
    access = 1'b0;
    ev     = 3'h0;
    s_d    = s_q;
    ost_start = 1'b0;
    setup  = I_PSEL && !I_PENABLE;
    access = I_PSEL && I_PENABLE && s_q.ready;

    // APB: answer one cycle after setup, with ready held only in the access.
    // Zero wait states: read data is latched at setup and stands in the access.
    // A status read therefore returns the bits seen before its own clear.
    s_d.ready  = setup;
    s_d.slverr = setup && !addr_hit(I_PADDR);
    if (setup) begin
      case (I_PADDR)
        SDC_OFF_DOZE_IDLE: s_d.rdata = {24'h000000, s_q.dz[7:4], 1'b0, s_q.dz[2:0]};
        SDC_OFF_OSC_SEL:   s_d.rdata = {27'h0000000, s_q.osc[4:0]};
        SDC_OFF_STATUS:    s_d.rdata = {29'h00000000, s_q.status};
        SDC_OFF_MASK:      s_d.rdata = {29'h00000000, s_q.mask};
        SDC_OFF_STATE:     s_d.rdata = {24'h000000, s_q.fail_safe_clock_monitor, s_q.pend,
                                        2'(s_q.pwr), 1'b0, s_q.active};
        default:           s_d.rdata = 32'h00000000;
      endcase
    end

    // Software writes take effect on the access edge.
    if (access && I_PWRITE) begin
      case (I_PADDR)
        SDC_OFF_DOZE_IDLE: begin
          s_d.dz = {I_PWDATA[7:4], 1'b0, I_PWDATA[2:0]};
        end
        SDC_OFF_OSC_SEL: begin
          s_d.osc = {3'h0, I_PWDATA[4:0]};
          if (I_PWDATA[2:0] != s_q.active) begin
            s_d.pend   = 1'b1;
            s_d.sw_cnt = SW_W'(SWITCH_CYCLES - 1);
          end else begin
            s_d.pend = 1'b0;
          end
        end
        SDC_OFF_MASK: s_d.mask = I_PWDATA[2:0];
        default: begin
          s_d.mask = s_d.mask;  // Read-only or unmapped: write ignored.
        end
      endcase
    end

    // Interrupt entry and return adjust reduced speed after any software write.
    // Return is applied last, so it wins if both strobes meet in one cycle.
    if (I_ISR_ENTRY && s_q.dz[SDC_BIT_WAKE_FULL]) begin
      s_d.dz[SDC_BIT_REDUCED] = 1'b0;  // RULE9
    end
    if (I_RETURN_INT && s_q.dz[SDC_BIT_RED_RET]) begin
      s_d.dz[SDC_BIT_REDUCED] = 1'b1;  // RULE10
    end

    // Power states.
    // RUN executes, IDLE stops only the CPU, SLEEP stops every clock,
    // and OST holds the CPU while the source starts up after a wake.
    // A switch never completes on the edge that takes the SLEEP pulse,
    // so an unfinished switch is dropped on the way into SLEEP rather than half done.
    case (s_q.pwr)
      SDC_RUN: begin
        if (s_q.pend && !s_q.osc[SDC_BIT_HOLD] && s_q.sw_cnt == '0 && !I_SLEEP_INSN) begin
          s_d.active = s_q.osc[SDC_SEL_LSB +: 3];
          s_d.pend   = 1'b0;
          ev[SDC_EV_SWITCH_DONE] = 1'b1;
        end else if (s_q.pend && s_q.sw_cnt != '0) begin
          s_d.sw_cnt = s_q.sw_cnt - 1'b1;
        end
        if (I_SLEEP_INSN) begin
          if (s_q.dz[SDC_BIT_IDLE_SEL]) begin
            s_d.pwr = SDC_IDLE;  // RULE7
          end else begin
            s_d.pwr  = SDC_SLEEP;  // RULE7
            s_d.wake_retry = s_q.pend;
            s_d.pend = 1'b0;  // RULE1
          end
        end
      end
      SDC_IDLE: begin
        // Peripherals keep running, so no start-up timer is needed.
        if (I_WAKE) begin
          s_d.pwr = SDC_RUN;
        end
      end
      SDC_SLEEP: begin
        // Only a switch that was dropped on the way into sleep is taken up again.
        // A software write made while asleep is left to the normal run path.
        if (I_WAKE) begin
          ost_start = 1'b1;  // RULE5
          s_d.pwr   = SDC_OST;
          s_d.wake_retry = 1'b0;
          ev[SDC_EV_WAKE] = 1'b1;
          if (s_q.wake_retry && (s_q.osc[SDC_SEL_LSB +: 3] != s_q.active)) begin
            if (!s_q.osc[SDC_BIT_HOLD]) begin
              s_d.active = s_q.osc[SDC_SEL_LSB +: 3];  // RULE2
              ev[SDC_EV_SWITCH_DONE] = 1'b1;  // RULE2
            end else begin
              s_d.pend   = 1'b1;  // RULE3
              s_d.sw_cnt = SW_W'(SWITCH_CYCLES - 1);
            end
          end
        end
      end
      SDC_OST: begin
        // CPU waits for the new source to settle, or goes on at once.
        if (ost_expired && !ost_start) begin
          s_d.pwr = SDC_RUN;
        end
      end
      default: s_d.pwr = SDC_RUN;
    endcase

    // Monitor watches only after the timer, never while asleep.
    // The timer's done flag still holds from the last run on the wake edge,
    // so the sleep term of the old state keeps the monitor off there.
    s_d.fail_safe_clock_monitor = ost_expired && (s_d.pwr != SDC_SLEEP) && (s_q.pwr != SDC_SLEEP);  // RULE4
    if (s_q.fail_safe_clock_monitor && I_OSC_FAIL) begin
      ev[SDC_EV_OSC_FAIL] = 1'b1;
    end

    // Status: read clears, but a new event in the same cycle wins.
    if (access && !I_PWRITE && I_PADDR == SDC_OFF_STATUS) begin
      s_d.status = 3'h0;
    end
    s_d.status = s_d.status | ev;
    s_d.irq    = |(s_d.status & s_d.mask);

    // CPU enable from the divider, off when the CPU clock is stopped.
    s_d.cpu_en = doze_en && (s_q.pwr == SDC_RUN);  // RULE8

    // Clock allows follow the next power state so they leave a flip-flop directly.
    s_d.cpu_run    = (s_d.pwr == SDC_RUN);  // RULE7
    s_d.periph_run = (s_d.pwr != SDC_SLEEP);  // RULE7
  end

  // State register.
  // Reset lands in the start-up state, so every reset runs the timer
  // and the CPU is held until the source is known to be stable.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_q <= '{dz: SDC_RST_DOZE_IDLE, osc: SDC_RST_OSC_SEL, active: 3'h0, pend: 1'b0,
               sw_cnt: '0, wake_retry: 1'b0, status: 3'h0, mask: SDC_RST_MASK,
               pwr: SDC_OST, ready: 1'b0, rdata: 32'h00000000, slverr: 1'b0,
               cpu_en: 1'b0, irq: 1'b0, fail_safe_clock_monitor: 1'b0, cpu_run: 1'b0, periph_run: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops.
  // No output passes through logic, so the core sees clean levels with no glitch.
  assign O_PREADY         = s_q.ready;
  assign O_PRDATA         = s_q.rdata;
  assign O_PSLVERR        = s_q.slverr;
  assign O_CPU_EN         = s_q.cpu_en;
  assign O_CPU_CLK_RUN    = s_q.cpu_run;
  assign O_PERIPH_CLK_RUN = s_q.periph_run;
  assign O_ACTIVE_SEL     = s_q.active;
  assign O_SWITCH_REQ     = s_q.pend;
  assign O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE    = s_q.fail_safe_clock_monitor;
  assign O_IRQ            = s_q.irq;

endmodule : sdc_top
`default_nettype wire

// ===== verif/sdc_core_model.sv
// Model of the core's peripheral cycle pacing and of an oscillator that can fail.
`timescale 1ns/1ps
`default_nettype none
module sdc_core_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_slow,       // Pulse every fourth cycle instead of every second.
  input  wire logic i_kill,       // Oscillator stops, so the monitor sees no clock.
  output logic      o_periph_en,  // Peripheral instruction cycle pulse.
  output logic      o_osc_fail    // Missing clock as seen by the monitor.
);
  logic [1:0] phase_q;  // Free-running phase of the peripheral cycle.
  // A power-of-two period means any window of whole periods holds a fixed pulse count.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      phase_q <= 2'h0;
    else
      phase_q <= phase_q + 2'h1;
  end
  assign o_periph_en = i_slow ? (phase_q == 2'h0) : !phase_q[0];
  assign o_osc_fail  = i_kill;
endmodule : sdc_core_model
`default_nettype wire

// ===== verif/sdc_top_asserts.sv
// Checker of port-level timing rules for the sleep and doze clock control block.
`timescale 1ns/1ps
`default_nettype none
module sdc_top_asserts #(
  parameter int OST_CYCLES = 8
) (
  input wire logic       I_CORE_CLK,
  input wire logic       I_RST_N,
  input wire logic       I_PSEL,
  input wire logic       I_PENABLE,
  input wire logic [7:0] I_PADDR,
  input wire logic       O_PREADY,
  input wire logic       O_PSLVERR,
  input wire logic       I_SLEEP_INSN,
  input wire logic       I_WAKE,
  input wire logic       I_DEBUG,
  input wire logic       I_PERIPH_EN,
  input wire logic       O_CPU_EN,
  input wire logic       O_CPU_CLK_RUN,
  input wire logic       O_PERIPH_CLK_RUN,
  input wire logic [2:0] O_ACTIVE_SEL,
  input wire logic       O_SWITCH_REQ,
  input wire logic       O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  int rst_cnt_q;  // Cycles since reset release, saturating at the timer length.
  // The counter restarts with every reset, since the timer must run again.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      rst_cnt_q <= 0;
    else if (rst_cnt_q < OST_CYCLES)
      rst_cnt_q <= rst_cnt_q + 1;
  end
  property p_ready_next; I_PSEL && !I_PENABLE |=> O_PREADY; endproperty
  a_ready_next: assert property (p_ready_next) else $error("ready late");
  property p_ready_src; O_PREADY |-> $past(I_PSEL) && !$past(I_PENABLE); endproperty
  a_ready_src: assert property (p_ready_src) else $error("stray ready");
  property p_slverr; O_PREADY && I_PADDR > 8'h10 |-> O_PSLVERR; endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped not refused");
  property p_en_src; O_CPU_EN |-> $past(I_PERIPH_EN); endproperty
  a_en_src: assert property (p_en_src) else $error("cpu cycle without pulse");
  property p_en_stop; !O_CPU_CLK_RUN && $past(!O_CPU_CLK_RUN) |-> !O_CPU_EN; endproperty
  a_en_stop: assert property (p_en_stop) else $error("cpu runs stopped");
  property p_debug_full;
    $past(I_DEBUG) && $past(I_PERIPH_EN) && $past(O_CPU_CLK_RUN) |-> O_CPU_EN;
  endproperty
  a_debug_full: assert property (p_debug_full) else $error("debug slowed");
  property p_fail_safe_clock_monitor_wait; rst_cnt_q < OST_CYCLES |-> !O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE; endproperty
  a_fail_safe_clock_monitor_wait: assert property (p_fail_safe_clock_monitor_wait) else $error("monitor early");
  property p_sleep_enter; I_SLEEP_INSN && O_CPU_CLK_RUN && !I_WAKE |=> !O_CPU_CLK_RUN;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep ignored");
  property p_sleep_drop;
    !O_PERIPH_CLK_RUN && !I_WAKE && !$past(I_WAKE) |-> !O_SWITCH_REQ && $stable(O_ACTIVE_SEL);
  endproperty
  a_sleep_drop: assert property (p_sleep_drop) else $error("switch in sleep");
  c_sleep: cover property (I_SLEEP_INSN && O_CPU_CLK_RUN);
  c_debug: cover property (I_DEBUG && O_CPU_EN);
  c_slverr: cover property (O_PREADY && O_PSLVERR);
endmodule : sdc_top_asserts
bind sdc_top sdc_top_asserts #(.OST_CYCLES(OST_CYCLES)) sdc_top_asserts_inst (
  .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PADDR(I_PADDR), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .I_SLEEP_INSN(I_SLEEP_INSN), .I_WAKE(I_WAKE), .I_DEBUG(I_DEBUG),
  .I_PERIPH_EN(I_PERIPH_EN), .O_CPU_EN(O_CPU_EN), .O_CPU_CLK_RUN(O_CPU_CLK_RUN),
  .O_PERIPH_CLK_RUN(O_PERIPH_CLK_RUN), .O_ACTIVE_SEL(O_ACTIVE_SEL),
  .O_SWITCH_REQ(O_SWITCH_REQ), .O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE(O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE));
`default_nettype wire

// ===== verif/sleep_doze_clock_control_bench.sv
// Self-checking bench for the sleep and doze clock control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module sleep_doze_clock_control_bench;
  import sdc_pkg::*;
  typedef struct packed { logic [7:0] doze; logic slow; logic dbg; int exp; } sdc_row_t;
  logic clk, rst_n, psel, pen, pwr, wake, dbg, slow, kill, cnt_on, serr;
  logic cpu_en, cclk, pclk, sreq, fail_safe_clock_monitor, irq, pready, pslverr, periph_en, osc_fail;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  ev, act;  // Event pulses: sleep, interrupt entry, return.
  int error_cnt, compares, cyc, n, cnt;
  // Doze value, pacing, debug, and CPU cycles expected in a 1024-cycle window.
  sdc_row_t rows [12] = '{'{8'h40, 1'b0, 1'b0, 256}, '{8'h41, 1'b0, 1'b0, 128},
    '{8'h42, 1'b0, 1'b0, 64}, '{8'h43, 1'b0, 1'b0, 32}, '{8'h44, 1'b0, 1'b0, 16},
    '{8'h45, 1'b0, 1'b0, 8}, '{8'h46, 1'b0, 1'b0, 4}, '{8'h47, 1'b0, 1'b0, 2},
    '{8'h00, 1'b0, 1'b0, 512}, '{8'h47, 1'b1, 1'b0, 1}, '{8'h47, 1'b0, 1'b1, 512},
    '{8'h03, 1'b1, 1'b0, 256}};
  // Written control value, event index, control value expected afterwards.
  logic [7:0] isr_tab [4][3] = '{'{8'h60, 8'h1, 8'h20}, '{8'h50, 8'h1, 8'h50},
    '{8'h30, 8'h2, 8'h70}, '{8'h60, 8'h2, 8'h60}};
  sdc_top #(.OST_CYCLES(8), .SWITCH_CYCLES(2)) sdc_top_inst (.I_CORE_CLK(clk),
    .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr),
    .I_SLEEP_INSN(ev[0]), .I_WAKE(wake), .I_ISR_ENTRY(ev[1]), .I_RETURN_INT(ev[2]),
    .I_DEBUG(dbg), .I_PERIPH_EN(periph_en), .I_OSC_FAIL(osc_fail), .O_CPU_EN(cpu_en),
    .O_CPU_CLK_RUN(cclk), .O_PERIPH_CLK_RUN(pclk), .O_ACTIVE_SEL(act),
    .O_SWITCH_REQ(sreq), .O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE(fail_safe_clock_monitor), .O_IRQ(irq));
  sdc_core_model sdc_core_model_inst (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow),
    .i_kill(kill), .o_periph_en(periph_en), .o_osc_fail(osc_fail));
  // The clock runs at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Counts CPU cycles in the window and cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cnt_on && cpu_en === 1'b1) cnt++;
    if (cyc > 40000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  // One APB transfer; the request holds until ready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin @(posedge clk); end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic pulse(input int k);
    @(posedge clk) ev[k] <= 1'b1;
    @(posedge clk) ev <= 3'h0;
    @(posedge clk);
  endtask : pulse
  // Holds wake until the CPU clock returns; n gives the cycles it took.
  task automatic rouse();
    @(posedge clk) wake <= 1'b1;
    n = 0;
    while (cclk !== 1'b1 && n < 60) begin @(posedge clk); n++; end
    wake <= 1'b0;
  endtask : rouse
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    while (fail_safe_clock_monitor !== 1'b1 && n < 60) begin @(posedge clk); n++; end
    `CHK("ost_reset", 1'b1, n >= 8 && n < 60)
  endtask : do_reset
  initial begin
    {rst_n, psel, pen, pwr, wake, dbg, slow, kill, cnt_on} = '0;
    {paddr, pwdata, ev} = '0;
    do_reset();
    foreach (rows[i]) begin
      apb(1'b1, SDC_OFF_DOZE_IDLE, {24'h0, rows[i].doze});
      slow <= rows[i].slow;
      dbg <= rows[i].dbg;
      repeat (16) @(posedge clk);
      cnt = 0;
      cnt_on <= 1'b1;
      repeat (1024) @(posedge clk);
      cnt_on <= 1'b0;
      @(posedge clk);
      `CHK("cpu_cycles", rows[i].exp, cnt)
      apb(1'b0, SDC_OFF_DOZE_IDLE, 32'h0);
      `CHK("doze_rd", rows[i].doze, rd[7:0])
    end
    {slow, dbg} <= 2'b00;
    do_reset();
    apb(1'b0, SDC_OFF_DOZE_IDLE, 32'h0);
    `CHK("doze_rst", {24'h0, SDC_RST_DOZE_IDLE}, rd)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 33'h100000000, {serr, rd})
    apb(1'b1, SDC_OFF_DOZE_IDLE, 32'hff);
    apb(1'b0, SDC_OFF_DOZE_IDLE, 32'h0);
    `CHK("doze_bit3", 32'hf7, rd)
    apb(1'b1, SDC_OFF_STATE, 32'hff);
    apb(1'b0, SDC_OFF_STATE, 32'h0);
    `CHK("state_ro", 32'h80, rd)
    apb(1'b1, SDC_OFF_DOZE_IDLE, 32'h0);
    apb(1'b1, SDC_OFF_MASK, 32'h1);
    apb(1'b1, SDC_OFF_OSC_SEL, 32'h1);
    repeat (8) @(posedge clk);
    `CHK("irq_on", 4'h9, {irq, act})
    apb(1'b0, SDC_OFF_STATUS, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq_clr", 33'h1, {irq, rd})
    apb(1'b1, SDC_OFF_MASK, 32'h0);
    apb(1'b1, SDC_OFF_OSC_SEL, 32'h2);
    repeat (8) @(posedge clk);
    apb(1'b0, SDC_OFF_STATUS, 32'h0);
    `CHK("irq_mask", 36'h200000001, {irq, act, rd})
    apb(1'b1, SDC_OFF_OSC_SEL, 32'h3);
    pulse(0);
    `CHK("sleep_drop", 6'h02, {cclk, pclk, sreq, act})
    rouse();
    `CHK("wake_new", 5'h13, {n >= 8 && n < 60, sreq, act})
    apb(1'b0, SDC_OFF_STATUS, 32'h0);
    `CHK("wake_flag", 3'h5, rd[2:0])
    apb(1'b1, SDC_OFF_OSC_SEL, 32'hc);
    repeat (6) @(posedge clk);
    `CHK("hold_run", 4'hb, {sreq, act})
    pulse(0);
    `CHK("hold_sleep", 4'h3, {sreq, act})
    rouse();
    `CHK("hold_wake", 4'hb, {sreq, act})
    apb(1'b0, SDC_OFF_STATUS, 32'h0);
    `CHK("hold_flag", 3'h4, rd[2:0])
    apb(1'b1, SDC_OFF_OSC_SEL, 32'h13);
    pulse(0);
    rouse();
    repeat (2) @(posedge clk);
    `CHK("ext_fast", 2'b11, {n < 6, fail_safe_clock_monitor})
    kill <= 1'b1;
    repeat (3) @(posedge clk);
    kill <= 1'b0;
    apb(1'b0, SDC_OFF_STATUS, 32'h0);
    `CHK("fail_flag", 3'h6, rd[2:0])
    foreach (isr_tab[i]) begin
      apb(1'b1, SDC_OFF_DOZE_IDLE, {24'h0, isr_tab[i][0]});
      pulse(int'(isr_tab[i][1]));
      apb(1'b0, SDC_OFF_DOZE_IDLE, 32'h0);
      `CHK("isr_doze", isr_tab[i][2], rd[7:0])
    end
    apb(1'b1, SDC_OFF_DOZE_IDLE, 32'h80);
    pulse(0);
    `CHK("idle", 2'b01, {cclk, pclk})
    rouse();
    `CHK("idle_wake", 1'b1, n < 4)
    stop_test();
  end
endmodule : sleep_doze_clock_control_bench
`default_nettype wire
